/* logic/pecq_cfg.svh */
// Constants of the quad-select parity checker
`ifndef PECQ_CFG_SVH
`define PECQ_CFG_SVH
// Error output level after reset and while idle (released)
`define PECQ_ERR_IDLE 1'b1
// Error output level while a failure is reported
`define PECQ_ERR_ACTIVE 1'b0
// Crossings from failing word to error output going low
`define PECQ_ERR_LATENCY 3
// Crossings the error output stays low
`define PECQ_ERR_HOLD 2
// Parity value that marks a valid word plus parity bit
`define PECQ_PAR_GOOD 1'b0
`endif

/* logic/pecq_checker.sv */
// Command/address parity checker for four-chip-select operation
`timescale 1ns/1ps
`include "pecq_cfg.svh"
module pecq_checker
    import pecq_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int CS_W = 4,
    parameter int CKE_W = 2,
    parameter int ODT_W = 2
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Differential input clock, sampled as two plain levels
    input wire logic ck_true_in,
    input wire logic ck_comp_in,
    // Address/command group and its late parity bit
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic [2:0] bank_address_in,
    input wire logic row_strobe_in_n,
    input wire logic column_strobe_in_n,
    input wire logic write_enable_in_n,
    input wire logic parity_bit_in,
    // Control inputs that never take part in the parity sum
    input wire logic [CS_W-1:0] chip_select_in_n,
    input wire logic [CKE_W-1:0] clock_enable_in,
    input wire logic [ODT_W-1:0] termination_enable_in,
    // Open-drain error pin: logical level, pin drive value and enable
    output logic parity_error_out_n,
    output logic err_pin_out,
    output logic err_pin_oe
);

    // Previous samples of the clock pair, for crossing detection
    logic ck_true_prev;
    logic ck_comp_prev;
    logic next_ck_true_prev;
    logic next_ck_comp_prev;
    // One-cycle strobe: the pair crossed with true rising
    logic xing;
    // Word now on the pins; parity and select of the word registered on the last crossing
    pecq_cmd_t cmd_word;
    logic word_par;
    logic word_sel;
    logic next_word_par;
    logic next_word_sel;
    // Failure pipeline, one stage per crossing
    logic fail1;
    logic fail2;
    logic next_fail1;
    logic next_fail2;
    // Error output hold state
    pecq_state_t st;
    pecq_state_t next_st;

    // Pack the covered group; control pins stay outside on purpose
    assign cmd_word = '{address: address_in, bank: bank_address_in,
        row_strobe_n: row_strobe_in_n, column_strobe_n: column_strobe_in_n,
        write_enable_n: write_enable_in_n};

    // Crossing = low/high pair turning into high/low; a stopped or stuck
    // clock yields no strobe, so the whole checker freezes
    assign xing = ck_true_in && !ck_comp_in && !ck_true_prev && ck_comp_prev;

    // Next values of the clock sample registers
    always_comb
    begin
        next_ck_true_prev = ck_true_in;
        next_ck_comp_prev = ck_comp_in;
    end

    // Clock sample registers; reset to the stopped (both-low) pattern
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ck_true_prev <= 1'b0;
            ck_comp_prev <= 1'b0;
        end
        else
        begin
            ck_true_prev <= next_ck_true_prev;
            ck_comp_prev <= next_ck_comp_prev;
        end
    end

    // Next values of the parity pipeline, advanced only on crossings
    always_comb
    begin
        next_word_par = word_par;
        next_word_sel = word_sel;
        next_fail1 = fail1;
        next_fail2 = fail2;
        if (xing)
        begin
            // Stage 0: reduce the word now, keep only its parity bit
            next_word_par = ^cmd_word;
            // Any low chip-select means the word is a live command
            next_word_sel = !(&chip_select_in_n);
            // Stage 1: late parity bit meets the word from the last crossing
            next_fail1 = word_sel && ((word_par ^ parity_bit_in) != `PECQ_PAR_GOOD);
            // Stage 2: pure delay to reach the three-crossing latency
            next_fail2 = fail1;
        end
    end

    // Parity pipeline registers
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            word_par <= 1'b0;
            word_sel <= 1'b0;
            fail1 <= 1'b0;
            fail2 <= 1'b0;
        end
        else
        begin
            word_par <= next_word_par;
            word_sel <= next_word_sel;
            fail1 <= next_fail1;
            fail2 <= next_fail2;
        end
    end

    // Next error state; failures seen while the output is low are
    // dropped, not queued, so up to three failing crossings in a row show as one pulse
    always_comb
    begin
        next_st = st;
        if (xing)
        begin
            case (st)
                PECQ_OK:
                begin
                    if (fail2)
                        next_st = PECQ_HOLD_A;
                end
                PECQ_HOLD_A:
                    next_st = PECQ_HOLD_B;
                PECQ_HOLD_B:
                    next_st = PECQ_OK;
                default:
                    next_st = PECQ_OK;
            endcase
        end
    end

    // Error state and output registers; reset releases the pin at once
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            st <= PECQ_OK;
            parity_error_out_n <= `PECQ_ERR_IDLE;
            err_pin_oe <= 1'b0;
        end
        else
        begin
            st <= next_st;
            parity_error_out_n <= (next_st == PECQ_OK) ? `PECQ_ERR_IDLE : `PECQ_ERR_ACTIVE;
            err_pin_oe <= (next_st != PECQ_OK);
        end
    end

    // Open drain: only ever pulls low, the board pull-up makes the high
    assign err_pin_out = 1'b0;

    // Assertion helpers: crossings seen since the output fell
    logic [2:0] low_xings;
    logic [2:0] next_low_xings;

    // Next helper count; cleared while the output is released
    always_comb
    begin
        next_low_xings = low_xings;
        if (parity_error_out_n)
            next_low_xings = 3'h0;
        else if (xing)
            next_low_xings = low_xings + 3'h1;
    end

    // Helper count register
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            low_xings <= 3'h0;
        else
            low_xings <= next_low_xings;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_fail_detect: assert property (xing && word_sel && (word_par ^ parity_bit_in) |=> fail1)
        else $error("odd parity on selected word not flagged");
    a_even_clean: assert property (xing && !(word_par ^ parity_bit_in) |=> !fail1)
        else $error("even parity flagged as failure");
    a_select_track: assert property (xing |=> word_sel == !(&$past(chip_select_in_n)))
        else $error("word select flag does not follow the chip-selects");
    a_deselect_clean: assert property (xing && !word_sel |=> !fail1)
        else $error("deselected word produced a failure");
    a_fall_cause: assert property ($fell(parity_error_out_n) |-> $past(fail2) && $past(xing))
        else $error("error output fell without a failure at a crossing");
    a_fall_when_high: assert property (xing && fail2 && parity_error_out_n |=> !parity_error_out_n)
        else $error("pending failure did not pull the output low");
    a_hold_two: assert property (!parity_error_out_n |-> low_xings <= 3'h2)
        else $error("error output held low past two crossings");
    a_release_exact: assert property ($rose(parity_error_out_n) |-> low_xings == 3'h2 && $past(xing))
        else $error("error output released at the wrong crossing");
    a_idle_stable: assert property (!xing |=> $stable(parity_error_out_n) && $stable(fail1))
        else $error("state changed without a clock crossing");
    a_oe_level: assert property (err_pin_oe == !parity_error_out_n)
        else $error("pin enable disagrees with error level");

    c_error_pulse: cover property ($fell(parity_error_out_n) ##[1:40] $rose(parity_error_out_n));
    c_deselect: cover property (xing && (&chip_select_in_n));
    c_err_while_low: cover property (xing && fail2 && !parity_error_out_n);
    c_clock_stop: cover property (!ck_true_in && !ck_comp_in && parity_error_out_n);

endmodule : pecq_checker

/* logic/pecq_pkg.sv */
// Types shared by the quad-select parity checker
package pecq_pkg;
    // One registered address/command word (the parity-covered group)
    typedef struct packed {
        logic [15:0] address;
        logic [2:0] bank;
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_enable_n;
    } pecq_cmd_t;

    // Error output hold states, Gray along ok -> hold_a -> hold_b; the step hold_b -> ok flips both bits
    typedef enum logic [1:0] {
        PECQ_OK = 2'h0,
        PECQ_HOLD_A = 2'h1,
        PECQ_HOLD_B = 2'h3
    } pecq_state_t;
endpackage : pecq_pkg

/* tb/pecq_checker_tb.sv */
// Self-checking bench for the quad-select parity checker
`timescale 1ns/1ps
module pecq_checker_tb;
    import pecq_pkg::*;
    logic mclk = 0, nrst = 0, run = 0, bad = 0, ck_t, ck_c, par, out_n, pin, oe, wire_n;
    logic ref_n = 1, pv_t, pv_c, f1, f2, sel_q;
    logic [3:0] cs_n, nxt_cs = 4'hF;
    logic [1:0] cke = 2'h0, odt = 2'h0;
    pecq_cmd_t word, word_q, nxt_word = '0;
    int fails = 0, n_tests = 0, hold = 0, bad_pct = 0, sel_pct = 0;
    assign wire_n = oe ? pin : 1'b1; // Pull-up on the open-drain line
    pecq_ctrl_model i_ctrl (.mclk(mclk), .run(run), .nxt_word(nxt_word),
        .nxt_cs_n(nxt_cs), .nxt_bad(bad), .ck_t(ck_t), .ck_c(ck_c), .word(word),
        .cs_n(cs_n), .par(par));
    pecq_checker i_dut (.mclk(mclk), .nrst(nrst), .ck_true_in(ck_t), .ck_comp_in(ck_c),
        .address_in(word.address), .bank_address_in(word.bank),
        .row_strobe_in_n(word.row_strobe_n), .column_strobe_in_n(word.column_strobe_n),
        .write_enable_in_n(word.write_enable_n), .parity_bit_in(par),
        .chip_select_in_n(cs_n), .clock_enable_in(cke), .termination_enable_in(odt),
        .parity_error_out_n(out_n), .err_pin_out(pin), .err_pin_oe(oe));
    initial forever #2 mclk = ~mclk;
    task automatic check(input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Expected failure: selected word whose ones plus late parity bit are odd
    function automatic logic exp_fail(input logic sel, input pecq_cmd_t w, input logic p);
        return sel && ((^w ^ p) != 1'b0);
    endfunction : exp_fail
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    // Reference: crossing decode, parity pipeline, two-crossing hold
    always @(posedge mclk)
    begin
        if (!nrst)
        begin
            {ref_n, pv_t, pv_c, f1, f2, sel_q} = 6'h20;
            hold = 0;
        end
        else
        begin
            if (ck_t && !ck_c && !pv_t && pv_c)
            begin
                hold = ref_n ? (f2 ? 2 : 0) : hold - 1;
                ref_n = (hold == 0);
                f2 = f1;
                f1 = exp_fail(sel_q, word_q, par);
                sel_q = !(&cs_n);
                word_q = word;
            end
            {pv_t, pv_c} = {ck_t, ck_c};
        end
    end
    // Compare every cycle, then draw new random stimulus; forked after seeding
    task automatic stim_loop;
        forever
        begin
            @(negedge mclk);
            check(out_n, ref_n);
            check(wire_n, ref_n);
            check(oe, !ref_n);
            nxt_word <= pecq_cmd_t'(22'($urandom));
            nxt_cs <= ($urandom % 100 < sel_pct) ? ~(4'h1 << ($urandom % 4)) : 4'hF;
            bad <= ($urandom % 100 < bad_pct);
            cke <= 2'($urandom);
            odt <= 2'($urandom);
        end
    endtask : stim_loop
    task automatic phase(input logic r, input int b, input int s, input int n,
        input string name);
        bad_pct <= b;
        sel_pct <= s;
        run <= r;
        repeat (n) @(negedge mclk);
        $display("test %s done, mismatches %0d", name, fails);
    endtask : phase
    initial
    begin
        void'($urandom(32'hB04D1244));
        // The stimulus thread inherits its random state from this seeded one
        fork
            stim_loop();
        join_none
        repeat (4) @(negedge mclk);
        nrst <= 1'b1;
        phase(1'b1, 0, 100, 40, "clean");
        phase(1'b1, 100, 100, 14, "back_to_back");
        phase(1'b1, 100, 0, 24, "deselected");
        // Stop only when no fall can land on a stopped clock
        while (!(ref_n && !f2)) @(negedge mclk);
        phase(1'b0, 100, 100, 20, "clock_stop");
        run <= 1'b1;
        while (ref_n) @(negedge mclk);
        nrst <= 1'b0;
        repeat (4) @(negedge mclk);
        nrst <= 1'b1;
        phase(1'b1, 30, 70, 2000, "random");
        print_verdict();
    end
    // Watchdog well beyond the planned run
    initial
    begin
        repeat (6000) @(posedge mclk);
        fails++;
        print_verdict();
    end
endmodule : pecq_checker_tb

/* tb/pecq_ctrl_model.sv */
// Controller model: clock pair, command word and late parity bit
`timescale 1ns/1ps
module pecq_ctrl_model
    import pecq_pkg::*;
(
    // Bench controls
    input wire logic mclk,
    input wire logic run,
    input wire pecq_cmd_t nxt_word,
    input wire logic [3:0] nxt_cs_n,
    input wire logic nxt_bad,
    // Pins toward the checker
    output logic ck_t,
    output logic ck_c,
    output pecq_cmd_t word,
    output logic [3:0] cs_n,
    output logic par
);
    logic par_q; // Parity owed for the word now on the pins
    initial {ck_t, ck_c, word, cs_n, par, par_q} = '0;
    // Pair steps 00->01->10->01; it only ever rests at 00
    always @(negedge mclk)
    begin
        ck_t <= run && ck_c;
        ck_c <= run && !ck_c;
        if (run && ck_c)
        begin
            // New word, with the parity of the word before it
            word <= nxt_word;
            cs_n <= nxt_cs_n;
            par <= par_q;
            par_q <= ^nxt_word ^ nxt_bad;
        end
        else
        begin
            // Off the crossing the lines change, so stale values never match
            word <= ~word;
            cs_n <= ~cs_n;
            par <= ~par;
        end
    end
endmodule : pecq_ctrl_model
